// ### rtl/vir_defines.svh
`ifndef VIR_DEFINES_SVH
`define VIR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define VIR_OFF_MODE_BASE 12'h000
`define VIR_OFF_VEC_BASE 12'h080
`define VIR_OFF_NORMAL_VEC 12'h100
`define VIR_OFF_FAST_VEC 12'h104
`define VIR_OFF_CUR_SRC 12'h108
`define VIR_OFF_PENDING 12'h10c
`define VIR_OFF_ENABLE 12'h110
`define VIR_OFF_CORE_STAT 12'h114
`define VIR_OFF_EN_CMD 12'h120
`define VIR_OFF_DIS_CMD 12'h124
`define VIR_OFF_CLR_CMD 12'h128
`define VIR_OFF_SET_CMD 12'h12c
`define VIR_OFF_EOI_CMD 12'h130
`define VIR_OFF_SPUR_VEC 12'h134
`define VIR_OFF_DEBUG 12'h138
`define VIR_OFF_EVT_STAT 12'h150
`define VIR_OFF_EVT_MASK 12'h154

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define VIR_DBG_PROTECTION_MODE_BIT 0
`define VIR_DBG_GENERAL_MASK_BIT 1
`define VIR_CORE_FAST_BIT 0
`define VIR_CORE_NORMAL_BIT 1
`define VIR_EVT_SPUR_NORMAL 0
`define VIR_EVT_SPUR_FAST 1
`define VIR_EVT_EOI 2
`define VIR_MODE_MASK 32'h0000_0067
`define VIR_FAST_SRC 5'h00

// ----------------------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------------------
`define VIR_RST_WORD 32'h0000_0000
`define VIR_RESP_OKAY 2'h0
`define VIR_RESP_SLVERR 2'h2

`endif

// ### rtl/vir_pkg.sv
package vir_pkg;
  typedef logic [31:0] vir_word_t;
  typedef logic [4:0] vir_src_t;
  typedef logic [2:0] vir_evt_t;

  typedef struct packed {
    logic fast_n;
    logic normal_n;
  } vir_lines_t;

  typedef struct packed {
    logic hit;
    logic err;
    vir_word_t data;
  } vir_rd_t;
endpackage

// ### rtl/vir_regif.sv
// ----------------------------------------------------------------------------
// Contract
// ----------------------------------------------------------------------------
// Contract
// - A fast vector read returns the handler address stored for source 0.
// - With no fast interrupt present, the fast vector read returns the spurious vector.
// - The current source register returns the number of the source being serviced.
// - The pending view has one bit per source, 1 while that source is pending.
// - The enable view has one bit per source, 1 while that source is enabled.
// - Core status bit 0 reads 1 while the fast request line is asserted low.
// - Core status bit 1 reads 1 while the normal request line is asserted low.
// - Writing 1 to an enable command bit enables that source, 0 leaves it alone.
// - Writing 1 to a disable command bit disables that source, 0 has no effect.
// - Writing 1 to a clear command bit clears that pending source, 0 has no effect.
// - Writing 1 to a set command bit makes that source pending, 0 has no effect.
// - Any write to the end-of-interrupt register ends the current treatment.
// - The spurious vector is read/write and is returned by a spurious normal vector read.
// - The spurious vector is also returned by a spurious fast vector read.
// - With the general mask bit set both request lines are held inactive.
// - The protection bit enables protection mode when 1 and disables it when 0.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`include "vir_defines.svh"

module vir_regif import vir_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [31:0] src_req,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic fast_request_line_n,
  output logic normal_request_line_n,
  output logic protection_mode,
  output logic irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  vir_word_t vec_mem [32];
  vir_word_t mode_mem [32];
  vir_word_t pending_q;
  vir_word_t enable_q;
  vir_word_t spur_vec_q;
  logic [1:0] debug_q;
  vir_src_t cur_src_q;
  logic in_service_q;
  vir_lines_t lines_q;
  vir_evt_t evt_q;
  vir_evt_t evt_mask_q;
  vir_evt_t evt_set;
  logic irq_q;
  logic awready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  vir_word_t rdata_q;
  logic [1:0] rresp_q;

  // --------------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------------
  // Fixed priority arbitration is done here, mode registers unused; the lowest numbered active
  // normal source wins, which keeps the vector path a single mux.
  vir_word_t active;
  logic fast_active;
  logic norm_valid;
  vir_src_t norm_src;

  assign active = pending_q & enable_q;
  assign fast_active = active[0];

  always_comb begin
    norm_valid = 1'b0;
    norm_src = 5'h00;
    for (int i = 31; i >= 1; i--) begin
      if (active[i]) begin
        norm_valid = 1'b1;
        norm_src = 5'(i);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  vir_word_t wmask;
  vir_word_t wr_data;
  logic wr_mapped;
  logic wr_mode;
  logic wr_vec;

  assign wr_fire = awready_q & s_axi_awvalid & s_axi_wvalid;
  assign rd_fire = arready_q & s_axi_arvalid;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wr_data = s_axi_wdata & wmask;
  assign wr_mode = s_axi_awaddr[11:7] == 5'h00;
  assign wr_vec = s_axi_awaddr[11:7] == 5'h01;

  logic cmd_en;
  logic cmd_dis;
  logic cmd_clr;
  logic cmd_set;
  logic cmd_eoi;
  logic cmd_spur;
  logic cmd_dbg;
  logic cmd_ivr_wr;
  logic cmd_evt_stat;
  logic cmd_evt_mask;

  always_comb begin
    cmd_en = 1'b0;
    cmd_dis = 1'b0;
    cmd_clr = 1'b0;
    cmd_set = 1'b0;
    cmd_eoi = 1'b0;
    cmd_spur = 1'b0;
    cmd_dbg = 1'b0;
    cmd_ivr_wr = 1'b0;
    cmd_evt_stat = 1'b0;
    cmd_evt_mask = 1'b0;
    wr_mapped = wr_mode | wr_vec;
    case ({s_axi_awaddr[11:2], 2'b00})
      `VIR_OFF_NORMAL_VEC: begin
        wr_mapped = 1'b1;
        cmd_ivr_wr = 1'b1;
      end
      // Read-only registers accept the write and drop it.
      `VIR_OFF_FAST_VEC, `VIR_OFF_CUR_SRC, `VIR_OFF_PENDING, `VIR_OFF_ENABLE, `VIR_OFF_CORE_STAT: begin
        wr_mapped = 1'b1;
      end
      `VIR_OFF_EN_CMD: begin
        wr_mapped = 1'b1;
        cmd_en = 1'b1;
      end
      `VIR_OFF_DIS_CMD: begin
        wr_mapped = 1'b1;
        cmd_dis = 1'b1;
      end
      `VIR_OFF_CLR_CMD: begin
        wr_mapped = 1'b1;
        cmd_clr = 1'b1;
      end
      `VIR_OFF_SET_CMD: begin
        wr_mapped = 1'b1;
        cmd_set = 1'b1;
      end
      `VIR_OFF_EOI_CMD: begin
        wr_mapped = 1'b1;
        cmd_eoi = 1'b1;
      end
      `VIR_OFF_SPUR_VEC: begin
        wr_mapped = 1'b1;
        cmd_spur = 1'b1;
      end
      `VIR_OFF_DEBUG: begin
        wr_mapped = 1'b1;
        cmd_dbg = 1'b1;
      end
      `VIR_OFF_EVT_STAT: begin
        wr_mapped = 1'b1;
        cmd_evt_stat = 1'b1;
      end
      `VIR_OFF_EVT_MASK: begin
        wr_mapped = 1'b1;
        cmd_evt_mask = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Vector acknowledge
  // --------------------------------------------------------------------------
  // In protection mode a debugger may read the vector registers freely; the
  // normal acknowledge then moves to a write of the normal vector register, and a fast vector read acknowledges nothing.
  logic rd_ivr;
  logic rd_fvr;
  logic ivr_ack;
  logic fvr_ack;

  assign rd_ivr = rd_fire & ({s_axi_araddr[11:2], 2'b00} == `VIR_OFF_NORMAL_VEC);
  assign rd_fvr = rd_fire & ({s_axi_araddr[11:2], 2'b00} == `VIR_OFF_FAST_VEC);
  assign ivr_ack = debug_q[`VIR_DBG_PROTECTION_MODE_BIT] ? (wr_fire & cmd_ivr_wr) : rd_ivr;
  assign fvr_ack = rd_fvr & ~debug_q[`VIR_DBG_PROTECTION_MODE_BIT];

  always_comb begin
    evt_set = 3'h0;
    evt_set[`VIR_EVT_SPUR_NORMAL] = ivr_ack & ~norm_valid;
    evt_set[`VIR_EVT_SPUR_FAST] = fvr_ack & ~fast_active;
    evt_set[`VIR_EVT_EOI] = wr_fire & cmd_eoi;
  end

  // --------------------------------------------------------------------------
  // Source state
  // --------------------------------------------------------------------------
  vir_word_t ack_clr;

  always_comb begin
    ack_clr = 32'h0;
    if (ivr_ack && norm_valid) begin
      ack_clr[norm_src] = 1'b1;
    end
    if (fvr_ack && fast_active) begin
      ack_clr[`VIR_FAST_SRC] = 1'b1;
    end
  end

  // A source that asserts in the same cycle as its clear stays pending.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pending_q <= `VIR_RST_WORD;
    end else begin
      pending_q <= (pending_q & ~ack_clr & ~((wr_fire && cmd_clr) ? wr_data : 32'h0))
        | src_req | ((wr_fire && cmd_set) ? wr_data : 32'h0);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enable_q <= `VIR_RST_WORD;
    end else if (wr_fire && cmd_en) begin
      enable_q <= enable_q | wr_data;
    end else if (wr_fire && cmd_dis) begin
      enable_q <= enable_q & ~wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur_src_q <= 5'h00;
      in_service_q <= 1'b0;
    end else if (ivr_ack && norm_valid) begin
      cur_src_q <= norm_src;
      in_service_q <= 1'b1;
    end else if (wr_fire && cmd_eoi) begin
      in_service_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      spur_vec_q <= `VIR_RST_WORD;
    end else if (wr_fire && cmd_spur) begin
      spur_vec_q <= (spur_vec_q & ~wmask) | wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      debug_q <= 2'h0;
    end else if (wr_fire && cmd_dbg && s_axi_wstrb[0]) begin
      debug_q <= s_axi_wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_fire && wr_vec) begin
      vec_mem[s_axi_awaddr[6:2]] <= (vec_mem[s_axi_awaddr[6:2]] & ~wmask) | wr_data;
    end
    if (wr_fire && wr_mode) begin
      mode_mem[s_axi_awaddr[6:2]] <= ((mode_mem[s_axi_awaddr[6:2]] & ~wmask) | wr_data) & `VIR_MODE_MASK;
    end
  end

  // --------------------------------------------------------------------------
  // Request lines
  // --------------------------------------------------------------------------
  // No nesting: a normal request is held off until the end-of-interrupt write.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lines_q <= '{fast_n: 1'b1, normal_n: 1'b1};
    end else begin
      lines_q.fast_n <= ~(fast_active & ~debug_q[`VIR_DBG_GENERAL_MASK_BIT]);
      lines_q.normal_n <= ~(norm_valid & ~in_service_q & ~debug_q[`VIR_DBG_GENERAL_MASK_BIT]);
    end
  end

  // --------------------------------------------------------------------------
  // Block events
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_q <= 3'h0;
    end else begin
      evt_q <= (evt_q & ~((wr_fire && cmd_evt_stat) ? wr_data[2:0] : 3'h0)) | evt_set;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_mask_q <= 3'h0;
    end else if (wr_fire && cmd_evt_mask && s_axi_wstrb[0]) begin
      evt_mask_q <= s_axi_wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_q & evt_mask_q);
    end
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  vir_rd_t rd;

  always_comb begin
    rd = '{hit: 1'b1, err: 1'b0, data: 32'h0};
    if (s_axi_araddr[11:7] == 5'h00) begin
      rd.data = mode_mem[s_axi_araddr[6:2]];
    end else if (s_axi_araddr[11:7] == 5'h01) begin
      rd.data = vec_mem[s_axi_araddr[6:2]];
    end else begin
      case ({s_axi_araddr[11:2], 2'b00})
        `VIR_OFF_NORMAL_VEC: rd.data = norm_valid ? vec_mem[norm_src] : spur_vec_q;
        `VIR_OFF_FAST_VEC: rd.data = fast_active ? vec_mem[`VIR_FAST_SRC] : spur_vec_q;
        `VIR_OFF_CUR_SRC: rd.data = {27'h0, cur_src_q};
        `VIR_OFF_PENDING: rd.data = pending_q;
        `VIR_OFF_ENABLE: rd.data = enable_q;
        `VIR_OFF_CORE_STAT: rd.data = {30'h0, ~lines_q.normal_n, ~lines_q.fast_n};
        `VIR_OFF_EN_CMD, `VIR_OFF_DIS_CMD, `VIR_OFF_CLR_CMD, `VIR_OFF_SET_CMD, `VIR_OFF_EOI_CMD: begin
          rd.data = 32'h0;
        end
        `VIR_OFF_SPUR_VEC: rd.data = spur_vec_q;
        `VIR_OFF_DEBUG: rd.data = {30'h0, debug_q};
        `VIR_OFF_EVT_STAT: rd.data = {29'h0, evt_q};
        `VIR_OFF_EVT_MASK: rd.data = {29'h0, evt_mask_q};
        default: rd = '{hit: 1'b0, err: 1'b1, data: 32'h0};
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  // Address and data are taken together so a command never sees stale data.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `VIR_RESP_OKAY;
    end else begin
      awready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `VIR_RESP_OKAY : `VIR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= `VIR_RST_WORD;
      rresp_q <= `VIR_RESP_OKAY;
    end else begin
      arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd.data;
        rresp_q <= rd.err ? `VIR_RESP_SLVERR : `VIR_RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign fast_request_line_n = lines_q.fast_n;
  assign normal_request_line_n = lines_q.normal_n;
  assign protection_mode = debug_q[`VIR_DBG_PROTECTION_MODE_BIT];
  assign irq = irq_q;

endmodule

// ### verification/test_vectored_irq_register_interface.sv
module test_vectored_irq_register_interface import vir_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [11:0] waddr;
    vir_word_t wdata;
    logic [11:0] raddr;
    vir_word_t exp;
  } vir_row_t;
  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] src_req = 32'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  vir_word_t s_axi_rdata, rd_q;
  logic fast_request_line_n, normal_request_line_n, protection_mode, irq, fast_seen_q, normal_seen_q;
  int num_errors = 0;
  int checks = 0;
  // Event status is read before the fast vector, since an idle fast vector read logs a spurious event.
  logic [11:0] rst_regs [9] = '{12'h150, 12'h154, 12'h104, 12'h108, 12'h10c, 12'h110, 12'h114, 12'h134, 12'h138};
  vir_row_t rows [10] = '{
    '{12'h134, 32'h1234_5670, 12'h134, 32'h1234_5670}, '{12'h120, 32'h0000_0006, 12'h110, 32'h0000_0006},
    '{12'h120, 32'h0000_0000, 12'h110, 32'h0000_0006}, '{12'h124, 32'h0000_0004, 12'h110, 32'h0000_0002},
    '{12'h12c, 32'h0000_0018, 12'h10c, 32'h0000_0018}, '{12'h128, 32'h0000_0008, 12'h10c, 32'h0000_0010},
    '{12'h10c, 32'hffff_ffff, 12'h10c, 32'h0000_0010}, '{12'h128, 32'h0000_0010, 12'h120, 32'h0000_0000},
    '{12'h080, 32'ha000_0000, 12'h104, 32'h1234_5670}, '{12'h114, 32'hffff_ffff, 12'h114, 32'h0000_0000}};

  always #5 clk_sys = ~clk_sys;

  vir_regif dut (
    .clk_sys(clk_sys), .rstn(rstn), .src_req(src_req), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fast_request_line_n(fast_request_line_n),
    .normal_request_line_n(normal_request_line_n), .protection_mode(protection_mode), .irq(irq)
  );
  vir_core_model u_core (
    .clk_sys(clk_sys), .rstn(rstn), .fast_request_line_n(fast_request_line_n),
    .normal_request_line_n(normal_request_line_n), .fast_seen_q(fast_seen_q), .normal_seen_q(normal_seen_q)
  );
  // ----------------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------------
  task automatic compare(input string what, input vir_word_t seen, input vir_word_t exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Ready is raised only after the answer shows, so every transfer also exercises a one-cycle stall.
  task automatic wr(input logic [11:0] a, input vir_word_t d, input logic [3:0] s = 4'hf);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    @(posedge clk_sys);
    while (s_axi_awready !== 1'b1) @(posedge clk_sys);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    resp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [11:0] a, input vir_word_t exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge clk_sys);
    while (s_axi_arready !== 1'b1) @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
    compare(what, rd_q, exp);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    compare("lines at reset", {fast_request_line_n, normal_request_line_n, protection_mode, irq}, 32'hc);
    foreach (rst_regs[i]) rd($sformatf("reset %h", rst_regs[i]), rst_regs[i], 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].waddr, rows[i].wdata);
      rd($sformatf("row %0d", i), rows[i].raddr, rows[i].exp);
    end
    wr(12'h120, 32'h1);
    src_req <= 32'h1;
    @(posedge clk_sys);
    src_req <= 32'h0;
    rd("core fast", 12'h114, 32'h1);
    compare("fast line", fast_request_line_n, 32'h0);
    rd("pending fast", 12'h10c, 32'h1);
    rd("fast vector", 12'h104, 32'ha000_0000);
    rd("core idle", 12'h114, 32'h0);
    wr(12'h084, 32'hb000_0004);
    wr(12'h12c, 32'h2);
    rd("core normal", 12'h114, 32'h2);
    rd("normal vector", 12'h100, 32'hb000_0004);
    rd("current source", 12'h108, 32'h1);
    rd("pending acked", 12'h10c, 32'h0);
    wr(12'h12c, 32'h2);
    compare("line in service", normal_request_line_n, 32'h1);
    wr(12'h130, 32'h0, 4'h0);
    compare("line after end", normal_request_line_n, 32'h0);
    wr(12'h138, 32'h2);
    compare("masked lines", {fast_request_line_n, normal_request_line_n}, 32'h3);
    rd("core masked", 12'h114, 32'h0);
    wr(12'h138, 32'h1);
    compare("protect on", {protection_mode, normal_request_line_n}, 32'h2);
    rd("debug", 12'h138, 32'h1);
    rd("protected vector", 12'h100, 32'hb000_0004);
    rd("protected pending", 12'h10c, 32'h2);
    wr(12'h138, 32'h0);
    compare("protect off", protection_mode, 32'h0);
    wr(12'h128, 32'h2);
    compare("line cleared", normal_request_line_n, 32'h1);
    wr(12'h150, 32'h7);
    wr(12'h154, 32'h0);
    rd("spurious normal", 12'h100, 32'h1234_5670);
    compare("irq masked", irq, 32'h0);
    wr(12'h154, 32'h1);
    compare("irq raised", irq, 32'h1);
    wr(12'h150, 32'h1);
    compare("irq cleared", irq, 32'h0);
    wr(12'h118, 32'hffff_ffff);
    compare("unmapped bresp", resp_q, 32'h2);
    rd("unmapped read", 12'h118, 32'h0);
    compare("unmapped rresp", resp_q, 32'h2);
    compare("core saw lines", {fast_seen_q, normal_seen_q}, 32'h3);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd("enable after reset", 12'h110, 32'h0);
    give_verdict();
  end
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule

// ### verification/vir_core_model.sv
// ----------------------------------------------------------------------------
// Core side of the request lines
// ----------------------------------------------------------------------------
module vir_core_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic fast_request_line_n,
  input wire logic normal_request_line_n,
  output logic fast_seen_q,
  output logic normal_seen_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // The core only listens, so it records that each line went active and drives nothing back.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fast_seen_q <= 1'b0;
      normal_seen_q <= 1'b0;
    end else begin
      fast_seen_q <= fast_seen_q | ~fast_request_line_n;
      normal_seen_q <= normal_seen_q | ~normal_request_line_n;
    end
  end
endmodule

// ### verification/vir_regif_props.sv
// ----------------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------------
module vir_regif_props (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fast_request_line_n,
  input wire logic normal_request_line_n,
  input wire logic protection_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence wr_hs;
    s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  endsequence
  sequence rd_hs;
    s_axi_arready && s_axi_arvalid;
  endsequence
  sequence dbg_wr;
    wr_hs ##0 (s_axi_awaddr == 12'h138 && s_axi_wstrb[0]);
  endsequence
  wr_ready_only_a: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid)
    else $error("write ready without a full request");
  wr_resp_next_a: assert property (wr_hs |=> s_axi_bvalid)
    else $error("write response late");
  wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  rd_resp_next_a: assert property (rd_hs |=> s_axi_rvalid)
    else $error("read data late");
  rd_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  rd_unmapped_a: assert property (rd_hs ##0 (s_axi_araddr == 12'h118) |=>
    s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered wrongly");
  cmd_read_zero_a: assert property (rd_hs ##0 (s_axi_araddr >= 12'h120 && s_axi_araddr <= 12'h130) |=>
    s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0) else $error("command register read not zero");
  gen_mask_a: assert property (dbg_wr ##0 s_axi_wdata[1] |-> ##2 (fast_request_line_n && normal_request_line_n))
    else $error("request line active under general mask");
  protection_mode_mode_a: assert property (dbg_wr |=> protection_mode == $past(s_axi_wdata[0]))
    else $error("protection mode does not follow debug bit 0");
endmodule

bind vir_regif vir_regif_props u_props (
  .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fast_request_line_n(fast_request_line_n),
  .normal_request_line_n(normal_request_line_n), .protection_mode(protection_mode)
);
